// file: hdl/dcr_regs.svh
/*
 * Constants of the digital datapath control register: address, field
 * positions, reset value and the serial port framing it is written through.
 * Assumes inclusion by every file that decodes or drives the register.
 */
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

`define DCR_ADDR_W          5
`define DCR_CTRL_ADDR       5'h01
`define DCR_INSTR_BITS      8
`define DCR_DATA_BITS       16
`define DCR_INSTR_RD_POS    7

`define DCR_CTRL_RESET      16'h0100
`define DCR_CTRL_WMASK      16'h7BFF

`define DCR_CLR_PHASE_POS   14
`define DCR_PN_EN_POS       13
`define DCR_SYNC_SEL_POS    12
`define DCR_PULSE_EN_POS    11
`define DCR_INV_SINC_POS    9
`define DCR_DCLK_OE_POS     8
`define DCR_INTERP_HI       7
`define DCR_INTERP_LO       6
`define DCR_FORMAT_POS      5
`define DCR_SINGLE_POS      4
`define DCR_REAL_POS        3
`define DCR_IQ_INV_POS      2
`define DCR_Q_FIRST_POS     1
`define DCR_MOD_GAIN_POS    0

`define DCR_SAMPLE_MSB      15
`define DCR_DCLK_DIV        4'h1

`endif

// file: hdl/dcr_pkg.sv
/*
 * Types shared by the datapath control register block.
 * Assumes the constants header is included alongside.
 */
package dcr_pkg;

    typedef enum logic [1:0] {
        DCR_INTERP_X1,
        DCR_INTERP_X2,
        DCR_INTERP_X4,
        DCR_INTERP_X8
    } dcr_interp_t;

    typedef enum logic [1:0] {
        DCR_SPI_IDLE,
        DCR_SPI_INSTR,
        DCR_SPI_DATA
    } dcr_spi_state_t;

endpackage

// file: hdl/dcr_nco_phase.sv
/*
 * NCO phase accumulator with hold-in-reset and modulator gain scaling.
 * Assumes a frequency word from logic on mclk and one step per cycle.
 */
`timescale 1ns/1ps
`include "dcr_regs.svh"

module dcr_nco_phase
    import dcr_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic [ACC_W-1:0]   ftw,
    input  wire logic               hold_clear,
    input  wire logic               half_gain,
    output logic      [ACC_W-1:0]   phase_q,
    output logic      [15:0]        nco_sample_q
);

    logic [15:0] raw_sample;

    assign raw_sample = phase_q[ACC_W-1 -: 16];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= '0;
        end else if (hold_clear) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + ftw;
        end
    end

    // Arithmetic halving keeps the sign so the modulator cannot saturate
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            nco_sample_q <= 16'h0000;
        end else if (half_gain) begin
            nco_sample_q <= {raw_sample[15], raw_sample[15:1]};
        end else begin
            nco_sample_q <= raw_sample;
        end
    end

endmodule

// file: hdl/dcr_iq_assembler.sv
/*
 * I/Q input assembler: dual-port or interleaved single-port capture, pairing
 * order, format conversion and real-only output.
 * Assumes port data and transmit enable already synchronised to mclk.
 */
`timescale 1ns/1ps
`include "dcr_regs.svh"

module dcr_iq_assembler
    import dcr_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           rstn,
    input  wire logic           word_valid,
    input  wire logic [15:0]    first_input_port,
    input  wire logic [15:0]    second_input_port,
    input  wire logic           transmit_enable,
    input  wire logic           single_port,
    input  wire logic           iq_invert,
    input  wire logic           q_first,
    input  wire logic           offset_binary,
    input  wire logic           real_mode,
    output logic      [15:0]    i_out_q,
    output logic      [15:0]    q_out_q,
    output logic                pair_valid_q
);

    logic [15:0] held_q;
    logic        held_ok_q;
    logic        is_i_word;

    // Offset binary becomes two's complement by inverting the sign bit
    function automatic logic [15:0] to_twos(input logic [15:0] w, input logic ob);
        to_twos = ob ? {~w[`DCR_SAMPLE_MSB], w[14:0]} : w;
    endfunction

    assign is_i_word = transmit_enable ^ iq_invert;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            held_q    <= 16'h0000;
            held_ok_q <= 1'b0;
        end else if (!single_port || !word_valid) begin
            held_ok_q <= held_ok_q & single_port;
        end else if (q_first ? !is_i_word : is_i_word) begin
            held_q    <= to_twos(first_input_port, offset_binary);
            held_ok_q <= 1'b1;
        end else if (!q_first) begin
            held_ok_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            i_out_q      <= 16'h0000;
            q_out_q      <= 16'h0000;
            pair_valid_q <= 1'b0;
        end else begin
            pair_valid_q <= 1'b0;
            if (word_valid && !single_port) begin
                i_out_q      <= to_twos(first_input_port, offset_binary);
                q_out_q      <= real_mode ? 16'h0000 :
                                to_twos(second_input_port, offset_binary);
                pair_valid_q <= 1'b1;
            end else if (word_valid && held_ok_q && !q_first && !is_i_word) begin
                i_out_q      <= held_q;
                q_out_q      <= real_mode ? 16'h0000 :
                                to_twos(first_input_port, offset_binary);
                pair_valid_q <= 1'b1;
            end else if (word_valid && held_ok_q && q_first && is_i_word) begin
                i_out_q      <= to_twos(first_input_port, offset_binary);
                q_out_q      <= real_mode ? 16'h0000 : held_q;
                pair_valid_q <= 1'b1;
            end
        end
    end

endmodule

// file: hdl/dcr_top.sv
/*
 * Digital datapath control register with its serial configuration port and
 * the datapath pieces it steers: I/Q assembly, NCO phase and gain, filter
 * selects, synchronization mode enables and the data clock pin.
 * Assumes the serial port pins and data pins come from outside mclk, and the
 * software reset level comes from the serial port config register on mclk.
 */
`timescale 1ns/1ps
`include "dcr_regs.svh"

module dcr_top
    import dcr_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               sw_reset,
    input  wire logic               spi_sclk,
    input  wire logic               spi_csn,
    input  wire logic               spi_sdio_in,
    output logic                    spi_sdio_out,
    output logic                    spi_sdio_oe,
    input  wire logic [15:0]        first_input_port,
    input  wire logic [15:0]        second_input_port,
    input  wire logic               transmit_enable_pin,
    input  wire logic [ACC_W-1:0]   nco_ftw,
    output logic      [15:0]        i_out,
    output logic      [15:0]        q_out,
    output logic                    pair_valid,
    output logic      [ACC_W-1:0]   nco_phase,
    output logic      [15:0]        nco_sample,
    output logic                    inv_sinc_enable,
    output dcr_interp_t             interp_rate,
    output logic                    pn_sync_enable,
    output logic                    sync_mode_pn,
    output logic                    pulse_sync_enable,
    output logic                    data_clock_out_pin,
    output logic                    data_clock_out_oe,
    output logic      [15:0]        ctrl_readback
);

    logic [2:0]         sclk_sync_q;
    logic [1:0]         csn_sync_q;
    logic [1:0]         sdi_sync_q;
    logic [15:0]        p1_meta_q;
    logic [15:0]        p1_sync_q;
    logic [15:0]        p2_meta_q;
    logic [15:0]        p2_sync_q;
    logic [1:0]         txen_sync_q;
    logic               word_valid_q;

    logic               sclk_rise;
    logic               sclk_fall;
    logic               csn_high;

    dcr_spi_state_t     spi_state_q;
    logic [4:0]         bit_cnt_q;
    logic [7:0]         instr_q;
    logic [15:0]        shift_in_q;
    logic [15:0]        shift_out_q;
    logic               is_read_q;
    logic               spi_oe_q;
    logic               wr_strobe_q;
    logic [15:0]        wr_data_q;
    logic [`DCR_ADDR_W-1:0] addr_q;

    logic [15:0]        ctrl_q;
    logic [3:0]         dclk_div_q;
    logic               dclk_q;

    logic [15:0]        i_asm;
    logic [15:0]        q_asm;
    logic               pair_asm;

    // Single address decode used for both read and write
    function automatic logic addr_hit(input logic [`DCR_ADDR_W-1:0] a);
        addr_hit = (a == `DCR_CTRL_ADDR);
    endfunction

    // Serial port pins arrive from the host's clock, so two stages first
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclk_sync_q <= 3'h0;
            csn_sync_q  <= 2'h3;
            sdi_sync_q  <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], spi_sclk};
            csn_sync_q  <= {csn_sync_q[0], spi_csn};
            sdi_sync_q  <= {sdi_sync_q[0], spi_sdio_in};
        end
    end

    // Edge detection looks only at the second stage and its delayed copy
    assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
    assign csn_high  = csn_sync_q[1];

    // Data pins and transmit enable also come from outside mclk
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            p1_meta_q    <= 16'h0000;
            p1_sync_q    <= 16'h0000;
            p2_meta_q    <= 16'h0000;
            p2_sync_q    <= 16'h0000;
            txen_sync_q  <= 2'h0;
            word_valid_q <= 1'b0;
        end else begin
            p1_meta_q    <= first_input_port;
            p1_sync_q    <= p1_meta_q;
            p2_meta_q    <= second_input_port;
            p2_sync_q    <= p2_meta_q;
            txen_sync_q  <= {txen_sync_q[0], transmit_enable_pin};
            // One word per data clock period, so the word rate matches the pin
            word_valid_q <= dclk_div_q == 4'h0 && !dclk_q;
        end
    end

    // Serial frame: one instruction byte, then sixteen data bits MSB first
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            spi_state_q <= DCR_SPI_IDLE;
            bit_cnt_q   <= 5'h00;
            instr_q     <= 8'h00;
            shift_in_q  <= 16'h0000;
            is_read_q   <= 1'b0;
            addr_q      <= '0;
        end else if (csn_high) begin
            spi_state_q <= DCR_SPI_IDLE;
            bit_cnt_q   <= 5'h00;
        end else begin
            unique case (spi_state_q)
                DCR_SPI_IDLE: begin
                    spi_state_q <= DCR_SPI_INSTR;
                    bit_cnt_q   <= 5'h00;
                end
                DCR_SPI_INSTR: begin
                    if (sclk_rise) begin
                        instr_q   <= {instr_q[6:0], sdi_sync_q[1]};
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                        if (bit_cnt_q == 5'(`DCR_INSTR_BITS - 1)) begin
                            spi_state_q <= DCR_SPI_DATA;
                            bit_cnt_q   <= 5'h00;
                            is_read_q   <= instr_q[`DCR_INSTR_RD_POS - 1];
                            addr_q      <= {instr_q[`DCR_ADDR_W-2:0], sdi_sync_q[1]};
                        end
                    end
                end
                DCR_SPI_DATA: begin
                    if (sclk_rise && bit_cnt_q != 5'(`DCR_DATA_BITS)) begin
                        shift_in_q <= {shift_in_q[14:0], sdi_sync_q[1]};
                        bit_cnt_q  <= bit_cnt_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // Write commits on the last data bit; an unmapped address is dropped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_strobe_q <= 1'b0;
            wr_data_q   <= 16'h0000;
        end else begin
            wr_strobe_q <= spi_state_q == DCR_SPI_DATA && sclk_rise && !is_read_q
                           && !csn_high && bit_cnt_q == 5'(`DCR_DATA_BITS - 1)
                           && addr_hit(addr_q);
            wr_data_q   <= {shift_in_q[14:0], sdi_sync_q[1]};
        end
    end

    // Readback shifts out on falling edges; unmapped addresses read zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shift_out_q <= 16'h0000;
            spi_oe_q    <= 1'b0;
        end else if (csn_high) begin
            spi_oe_q    <= 1'b0;
        end else if (spi_state_q == DCR_SPI_INSTR && sclk_rise
                     && bit_cnt_q == 5'(`DCR_INSTR_BITS - 1)) begin
            shift_out_q <= (instr_q[`DCR_INSTR_RD_POS - 1]
                            && addr_hit({instr_q[`DCR_ADDR_W-2:0], sdi_sync_q[1]}))
                           ? ctrl_q : 16'h0000;
            spi_oe_q    <= instr_q[`DCR_INSTR_RD_POS - 1];
        end else if (spi_state_q == DCR_SPI_DATA && sclk_fall && is_read_q
                     && bit_cnt_q != 5'h00) begin
            shift_out_q <= {shift_out_q[14:0], 1'b0};
        end
    end

    assign spi_sdio_out = shift_out_q[15];
    assign spi_sdio_oe  = spi_oe_q;

    // Software reset wins over a write landing in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `DCR_CTRL_RESET;
        end else if (sw_reset) begin
            ctrl_q <= `DCR_CTRL_RESET;
        end else if (wr_strobe_q) begin
            ctrl_q <= wr_data_q & `DCR_CTRL_WMASK;
        end
    end

    assign ctrl_readback = ctrl_q;

    // Mode selects feed the sync and filter logic outside this block
    assign pn_sync_enable    = ctrl_q[`DCR_PN_EN_POS];
    assign sync_mode_pn      = ctrl_q[`DCR_SYNC_SEL_POS];
    assign pulse_sync_enable = ctrl_q[`DCR_PULSE_EN_POS];
    assign inv_sinc_enable   = ctrl_q[`DCR_INV_SINC_POS];
    assign interp_rate       = dcr_interp_t'(ctrl_q[`DCR_INTERP_HI:`DCR_INTERP_LO]);

    // Data clock is mclk divided down; enable pulses pace the input words
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dclk_div_q <= 4'h0;
            dclk_q     <= 1'b0;
        end else if (dclk_div_q == `DCR_DCLK_DIV) begin
            dclk_div_q <= 4'h0;
            dclk_q     <= ~dclk_q;
        end else begin
            dclk_div_q <= dclk_div_q + 4'h1;
        end
    end

    assign data_clock_out_pin = dclk_q;
    assign data_clock_out_oe  = ctrl_q[`DCR_DCLK_OE_POS];

    dcr_iq_assembler u_asm (
        .mclk              (mclk),
        .rstn              (rstn),
        .word_valid        (word_valid_q),
        .first_input_port  (p1_sync_q),
        .second_input_port (p2_sync_q),
        .transmit_enable   (txen_sync_q[1]),
        .single_port       (ctrl_q[`DCR_SINGLE_POS]),
        .iq_invert         (ctrl_q[`DCR_IQ_INV_POS]),
        .q_first           (ctrl_q[`DCR_Q_FIRST_POS]),
        .offset_binary     (ctrl_q[`DCR_FORMAT_POS]),
        .real_mode         (ctrl_q[`DCR_REAL_POS]),
        .i_out_q           (i_asm),
        .q_out_q           (q_asm),
        .pair_valid_q      (pair_asm)
    );

    assign i_out      = i_asm;
    assign q_out      = q_asm;
    assign pair_valid = pair_asm;

    dcr_nco_phase #(
        .ACC_W (ACC_W)
    ) u_nco (
        .mclk         (mclk),
        .rstn         (rstn),
        .ftw          (nco_ftw),
        .hold_clear   (ctrl_q[`DCR_CLR_PHASE_POS]),
        .half_gain    (ctrl_q[`DCR_MOD_GAIN_POS]),
        .phase_q      (nco_phase),
        .nco_sample_q (nco_sample)
    );

endmodule

// file: dv/dcr_top_asserts.sv
/*
 * Concurrent checks on the ports of the datapath control register top.
 * Assumes one mclk domain with active-low asynchronous rstn.
 */
`timescale 1ns/1ps

module dcr_top_asserts
    import dcr_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input wire logic               mclk,
    input wire logic               rstn,
    input wire logic               sw_reset,
    input wire logic [ACC_W-1:0]   nco_ftw,
    input wire logic [15:0]        q_out,
    input wire logic               pair_valid,
    input wire logic [ACC_W-1:0]   nco_phase,
    input wire logic               inv_sinc_enable,
    input wire dcr_interp_t        interp_rate,
    input wire logic               pn_sync_enable,
    input wire logic               sync_mode_pn,
    input wire logic               pulse_sync_enable,
    input wire logic               data_clock_out_pin,
    input wire logic               data_clock_out_oe,
    input wire logic [15:0]        ctrl_readback
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Three cycles allow for one staging register between field and datapath
    sequence hold_req_s;
        ctrl_readback[14] [*3];
    endsequence
    sequence run_req_s;
        !ctrl_readback[14] [*3];
    endsequence
    sequence real_held_s;
        ctrl_readback[3] [*4];
    endsequence

    chk_reserved_zero: assert property (
        ctrl_readback[15] == 1'b0 && ctrl_readback[10] == 1'b0)
        else $error("reserved control bit reads one");
    chk_sinc_follows: assert property (
        $stable(ctrl_readback) |-> inv_sinc_enable == ctrl_readback[9])
        else $error("filter select differs from its bit");
    chk_pn_follows: assert property (
        $stable(ctrl_readback) |-> pn_sync_enable == ctrl_readback[13])
        else $error("code sync enable differs from its bit");
    chk_mode_follows: assert property (
        $stable(ctrl_readback) |-> sync_mode_pn == ctrl_readback[12])
        else $error("sync method differs from its bit");
    chk_pulse_follows: assert property (
        $stable(ctrl_readback) |-> pulse_sync_enable == ctrl_readback[11])
        else $error("pulse sync enable differs from its bit");
    chk_interp_follows: assert property (
        $stable(ctrl_readback) |-> interp_rate == ctrl_readback[7:6])
        else $error("interpolation rate differs from its field");
    chk_oe_follows: assert property (
        $stable(ctrl_readback) |-> data_clock_out_oe == ctrl_readback[8])
        else $error("data clock enable differs from its bit");
    chk_dclk_toggle: assert property (
        data_clock_out_oe [*3] ##0 $past(rstn, 6) |->
            data_clock_out_pin != $past(data_clock_out_pin, 2))
        else $error("data clock pin is not a quarter-rate square wave");
    chk_phase_hold: assert property (
        hold_req_s |-> nco_phase == '0)
        else $error("phase moved while held");
    chk_phase_step: assert property (
        run_req_s |=> nco_phase == $past(nco_phase) + $past(nco_ftw))
        else $error("phase did not advance by the tuning word");
    chk_swreset_value: assert property (
        sw_reset |=> ctrl_readback == 16'h0100)
        else $error("software reset did not restore the control value");
    chk_real_q_zero: assert property (
        real_held_s ##0 pair_valid |-> q_out == 16'h0000)
        else $error("Q word present in real mode");
    chk_pair_spacing: assert property (
        pair_valid |=> !pair_valid [*3])
        else $error("pairs closer than the word rate");
endmodule

bind dcr_top dcr_top_asserts #(.ACC_W(ACC_W)) i_chk (
    .mclk, .rstn, .sw_reset, .nco_ftw, .q_out, .pair_valid, .nco_phase,
    .inv_sinc_enable, .interp_rate, .pn_sync_enable, .sync_mode_pn,
    .pulse_sync_enable, .data_clock_out_pin, .data_clock_out_oe, .ctrl_readback
);

// file: dv/tb_top.sv
/*
 * Self-checking bench for the datapath control register top.
 * Assumes the bench itself drives the serial port, data pins and tuning word.
 */
`timescale 1ns/1ps

module tb_top
    import dcr_pkg::*;
;
    localparam int ACC_W = 32;

    logic               mclk = 1'b0;
    logic               rstn = 1'b0;
    logic               sw_reset = 1'b0;
    logic               spi_sclk = 1'b0;
    logic               spi_csn = 1'b1;
    logic               spi_sdio_in = 1'b0;
    logic               spi_sdio_out;
    logic               spi_sdio_oe;
    logic               oe_mid = 1'b0;
    logic [15:0]        first_input_port = 16'h0000;
    logic [15:0]        second_input_port = 16'h0000;
    logic               transmit_enable_pin = 1'b0;
    logic [ACC_W-1:0]   nco_ftw = '0;
    logic [15:0]        i_out;
    logic [15:0]        q_out;
    logic [ACC_W-1:0]   nco_phase;
    logic [15:0]        nco_sample;
    logic               inv_sinc_enable;
    dcr_interp_t        interp_rate;
    logic               pn_sync_enable;
    logic               sync_mode_pn;
    logic               pulse_sync_enable;
    logic               data_clock_out_oe;
    logic [15:0]        ctrl_readback;
    int                 err_total = 0;
    int                 checks = 0;

    always #5 mclk = ~mclk;

    dcr_top #(.ACC_W(ACC_W)) i_dut (
        .mclk(mclk), .rstn(rstn), .sw_reset(sw_reset), .spi_sclk(spi_sclk),
        .spi_csn(spi_csn), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe), .first_input_port(first_input_port),
        .second_input_port(second_input_port),
        .transmit_enable_pin(transmit_enable_pin), .nco_ftw(nco_ftw),
        .i_out(i_out), .q_out(q_out), .pair_valid(), .nco_phase(nco_phase),
        .nco_sample(nco_sample), .inv_sinc_enable(inv_sinc_enable),
        .interp_rate(interp_rate), .pn_sync_enable(pn_sync_enable),
        .sync_mode_pn(sync_mode_pn), .pulse_sync_enable(pulse_sync_enable),
        .data_clock_out_pin(), .data_clock_out_oe(data_clock_out_oe),
        .ctrl_readback(ctrl_readback)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Six-cycle phases let the two-stage synchroniser see every serial edge
    task automatic spi(input logic rd, input logic [4:0] adr, input logic [15:0] wd,
                       input int nb, output logic [15:0] rq);
        logic [23:0] sh;
        sh = {rd, 2'b00, adr, wd};
        rq = 16'h0000;
        @(posedge mclk);
        spi_csn <= 1'b0;
        tick(6);
        for (int i = 0; i < nb; i++) begin
            spi_sdio_in <= sh[23-i];
            tick(6);
            spi_sclk <= 1'b1;
            tick(6);
            // Read bits are taken while sclk is high in the data phase
            if (i >= 8 && i < 24) rq[23-i] = spi_sdio_out;
            if (i == 12) oe_mid = spi_sdio_oe;
            spi_sclk <= 1'b0;
        end
        tick(6);
        spi_csn <= 1'b1;
        tick(8);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] x;
        spi(1'b0, a, d, 24, x);
        cmp16({15'h0000, oe_mid}, 16'h0000);
    endtask

    task automatic chk_reg(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] x;
        spi(1'b1, a, 16'h0000, 24, x);
        cmp16(x, e);
        cmp16({15'h0000, oe_mid}, 16'h0001);
        cmp16({15'h0000, spi_sdio_oe}, 16'h0000);
    endtask

    task automatic chk_levels(input logic [15:0] e);
        @(negedge mclk);
        cmp16({2'b00, pn_sync_enable, sync_mode_pn, pulse_sync_enable, 1'b0,
               inv_sinc_enable, data_clock_out_oe, interp_rate, 6'h00}, e & 16'h3BC0);
    endtask

    // Twelve cycles per word: three samples at the fixed word rate
    task automatic word(input logic [15:0] a, input logic [15:0] b, input logic t);
        @(posedge mclk);
        first_input_port <= a;
        second_input_port <= b;
        transmit_enable_pin <= t;
        tick(12);
        @(negedge mclk);
    endtask

    task automatic finish_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        tick(100000);
        err_total++;
        finish_test();
    end

    initial begin
        logic [15:0] v;
        logic [31:0] p0;
        tick(16);
        rstn <= 1'b1;
        tick(4);
        chk_levels(16'h0100);
        cmp16(ctrl_readback, 16'h0100);
        for (int k = 0; k < 18; k++) begin
            v = (k < 16) ? 16'h0001 << k : (k == 16 ? 16'h00C0 : 16'hFFFF);
            wr(5'h01, v);
            chk_reg(5'h01, v & 16'h7BFF);
            chk_levels(v);
        end
        wr(5'h02, 16'h0000);
        chk_reg(5'h01, 16'h7BFF);
        chk_reg(5'h02, 16'h0000);
        spi(1'b0, 5'h01, 16'h0000, 16, v);
        chk_reg(5'h01, 16'h7BFF);
        sw_reset <= 1'b1;
        wr(5'h01, 16'h0A5A);
        cmp16(ctrl_readback, 16'h0100);
        sw_reset <= 1'b0;
        chk_reg(5'h01, 16'h0100);
        wr(5'h01, 16'h0020);
        word(16'h1234, 16'hABCD, 1'b1);
        cmp16(i_out, 16'h9234);
        cmp16(q_out, 16'h2BCD);
        wr(5'h01, 16'h0008);
        word(16'h1234, 16'hABCD, 1'b1);
        cmp16(i_out, 16'h1234);
        cmp16(q_out, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            wr(5'h01, 16'h0010 | 16'(m << 1));
            for (int w = 0; w < 5; w++)
                word(16'h1111 * 16'(w + 1), 16'h0F0F, ~m[1] ^ w[0]);
            cmp16(i_out, m[0] ? 16'h5555 : 16'h3333);
            cmp16(q_out, 16'h4444);
        end
        wr(5'h01, 16'h4000);
        nco_ftw <= 32'h12345678;
        tick(4);
        @(negedge mclk);
        cmp32(nco_phase, 32'h00000000);
        wr(5'h01, 16'h0000);
        @(negedge mclk);
        p0 = nco_phase;
        @(negedge mclk);
        cmp32(nco_phase, p0 + 32'h12345678);
        @(posedge mclk);
        nco_ftw <= 32'h00000000;
        tick(4);
        @(negedge mclk);
        p0 = nco_phase;
        cmp16(nco_sample, p0[31:16]);
        wr(5'h01, 16'h0001);
        tick(4);
        @(negedge mclk);
        cmp16(nco_sample, {p0[31], p0[31:17]});
        @(posedge mclk);
        rstn <= 1'b0;
        tick(3);
        rstn <= 1'b1;
        tick(4);
        chk_reg(5'h01, 16'h0100);
        finish_test();
    end
endmodule
